// ==== hw/uart_stat_pkg.sv ====
package uart_stat_pkg;

  // Register offsets are byte addresses on the local register port.
  localparam logic [31:0] LINE_STATUS_OFFS = 32'h7E21_5054;
  localparam logic [31:0] MODEM_STATUS_OFFS = 32'h7E21_5058;
  localparam logic [31:0] SCRATCH_BYTE_OFFS = 32'h7E21_505C;
  localparam logic [31:0] EXTRA_CONTROL_OFFS = 32'h7E21_5060;
  localparam logic [31:0] EXTRA_STATUS_OFFS = 32'h7E21_5064;
  localparam logic [31:0] MODEM_CONTROL_OFFS = 32'h7E21_5050;

  // Line status bit positions.
  localparam int LS_TX_IDLE_BIT = 6;
  localparam int LS_TX_SPACE_BIT = 5;
  localparam int LS_OVERRUN_BIT = 1;
  localparam int LS_DATA_READY_BIT = 0;

  // Modem status bit position.
  localparam int MS_CTS_INV_BIT = 5;

  // Modem control bit position.
  localparam int MC_RTS_BIT = 1;

  // Extra status bit positions.
  localparam int ES_TX_LEVEL_LSB = 24;
  localparam int ES_RX_LEVEL_LSB = 16;
  localparam int ES_TX_DONE_BIT = 9;
  localparam int ES_TX_EMPTY_BIT = 8;
  localparam int ES_CTS_BIT = 7;
  localparam int ES_RTS_BIT = 6;
  localparam int ES_TX_FULL_BIT = 5;
  localparam int ES_OVERRUN_BIT = 4;
  localparam int ES_TX_IDLE_BIT = 3;
  localparam int ES_RX_IDLE_BIT = 2;
  localparam int ES_TX_SPACE_BIT = 1;
  localparam int ES_RX_AVAIL_BIT = 0;

  // FIFO geometry.
  localparam logic [3:0] FIFO_DEPTH = 4'h8;

  // Reset values.
  localparam logic [7:0] SCRATCH_RST = 8'h00;
  localparam logic MODEM_RTS_RST = 1'b0;

  typedef struct packed {
    logic cts_low_active;
    logic rts_low_active;
    logic [1:0] rts_level;
    logic tx_flow_en;
    logic rx_flow_en;
    logic tx_en;
    logic rx_en;
  } extra_control_type;

  localparam extra_control_type EXTRA_CONTROL_RST = 8'h03;

  // Status coming from the surrounding transmitter, receiver and FIFOs.
  typedef struct packed {
    logic [3:0] tx_level;
    logic [3:0] rx_level;
    logic tx_shift_idle;
    logic rx_shift_idle;
  } core_status_type;

endpackage : uart_stat_pkg

// ==== hw/uart_status_and_flow_control.sv ====
`timescale 1ns/10ps

module uart_status_and_flow_control
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire uart_stat_pkg::core_status_type core_i,
  input wire logic rx_char_done_i,
  input wire logic tx_start_req_i,
  input wire logic rx_start_req_i,
  input wire logic clear_to_send_pin_i,
  output logic request_to_send_pin_o,
  output logic tx_start_ok_o,
  output logic rx_start_ok_o,
  output logic rx_store_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.

  uart_stat_pkg::extra_control_type ctrl_ff;
  logic [7:0] scratch_ff;
  logic modem_rts_ff;
  logic overrun_ff;
  logic [31:0] rdata_ff;
  logic rts_ff;

  logic rd_line_status;
  logic rx_full;
  logic tx_empty;
  logic tx_space;
  logic tx_idle;
  logic cts_asserted;
  logic [3:0] rx_free;
  logic [3:0] rts_threshold;
  logic rtr_level;
  logic nxt_rts;

  assign rd_line_status = rd_i && (addr_i == uart_stat_pkg::LINE_STATUS_OFFS);

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ctrl_ff <= uart_stat_pkg::EXTRA_CONTROL_RST;
    end
    else if (wr_i && addr_i == uart_stat_pkg::EXTRA_CONTROL_OFFS)
    begin
      ctrl_ff <= wdata_i[7:0];
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      scratch_ff <= uart_stat_pkg::SCRATCH_RST;
    end
    else if (wr_i && addr_i == uart_stat_pkg::SCRATCH_BYTE_OFFS)
    begin
      scratch_ff <= wdata_i[7:0];
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      modem_rts_ff <= uart_stat_pkg::MODEM_RTS_RST;
    end
    else if (wr_i && addr_i == uart_stat_pkg::MODEM_CONTROL_OFFS)
    begin
      modem_rts_ff <= wdata_i[uart_stat_pkg::MC_RTS_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // FIFO derived status.

  assign rx_full = (core_i.rx_level >= uart_stat_pkg::FIFO_DEPTH);
  assign tx_empty = (core_i.tx_level == 4'h0);
  assign tx_space = (core_i.tx_level < uart_stat_pkg::FIFO_DEPTH);
  assign tx_idle = tx_empty && core_i.tx_shift_idle;
  assign rx_free = rx_full ? 4'h0 : uart_stat_pkg::FIFO_DEPTH - core_i.rx_level;

  // A new overrun in the same cycle as the clearing read wins, so no event is lost.
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      overrun_ff <= 1'b0;
    end
    else if (rx_char_done_i && rx_full)
    begin
      overrun_ff <= 1'b1;
    end
    else if (rd_line_status)
    begin
      overrun_ff <= 1'b0;
    end
  end

  // Completed characters are stored only when there is room.
  assign rx_store_o = rx_char_done_i && !rx_full;

  ////////////////////////////////////////////////////////////////////////////////
  // Flow control.

  always_comb
  begin
    case (ctrl_ff.rts_level)
      2'h0: rts_threshold = 4'h3;
      2'h1: rts_threshold = 4'h2;
      2'h2: rts_threshold = 4'h1;
      default: rts_threshold = 4'h4;
    endcase
  end

  // Ready to receive holds while free entries exceed the threshold.
  assign rtr_level = (rx_free > rts_threshold);

  always_comb
  begin
    if (ctrl_ff.rx_flow_en)
    begin
      nxt_rts = ctrl_ff.rts_low_active ? !rtr_level : rtr_level;
    end
    else
    begin
      nxt_rts = !modem_rts_ff;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rts_ff <= 1'b1;
    end
    else
    begin
      rts_ff <= nxt_rts;
    end
  end

  assign request_to_send_pin_o = rts_ff;

  assign cts_asserted = ctrl_ff.cts_low_active ? !clear_to_send_pin_i
                                               : clear_to_send_pin_i;

  // Only the start of a symbol is gated, so a symbol already underway completes.
  assign tx_start_ok_o = tx_start_req_i && ctrl_ff.tx_en && !tx_empty
                         && (!ctrl_ff.tx_flow_en || cts_asserted);
  assign rx_start_ok_o = rx_start_req_i && ctrl_ff.rx_en;

  ////////////////////////////////////////////////////////////////////////////////
  // Read data.

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rdata_ff <= 32'h0000_0000;
    end
    else if (rd_i)
    begin
      rdata_ff <= 32'h0000_0000;
      if (addr_i == uart_stat_pkg::LINE_STATUS_OFFS)
      begin
        rdata_ff[uart_stat_pkg::LS_TX_IDLE_BIT] <= tx_idle;
        rdata_ff[uart_stat_pkg::LS_TX_SPACE_BIT] <= tx_space;
        rdata_ff[uart_stat_pkg::LS_OVERRUN_BIT] <= overrun_ff;
        rdata_ff[uart_stat_pkg::LS_DATA_READY_BIT] <= (core_i.rx_level != 4'h0);
      end
      else if (addr_i == uart_stat_pkg::MODEM_STATUS_OFFS)
      begin
        rdata_ff[uart_stat_pkg::MS_CTS_INV_BIT] <= !clear_to_send_pin_i;
      end
      else if (addr_i == uart_stat_pkg::SCRATCH_BYTE_OFFS)
      begin
        rdata_ff[7:0] <= scratch_ff;
      end
      else if (addr_i == uart_stat_pkg::EXTRA_CONTROL_OFFS)
      begin
        rdata_ff[7:0] <= ctrl_ff;
      end
      else if (addr_i == uart_stat_pkg::MODEM_CONTROL_OFFS)
      begin
        rdata_ff[uart_stat_pkg::MC_RTS_BIT] <= modem_rts_ff;
      end
      else if (addr_i == uart_stat_pkg::EXTRA_STATUS_OFFS)
      begin
        rdata_ff[uart_stat_pkg::ES_TX_LEVEL_LSB +: 4] <= core_i.tx_level;
        rdata_ff[uart_stat_pkg::ES_RX_LEVEL_LSB +: 4] <= core_i.rx_level;
        rdata_ff[uart_stat_pkg::ES_TX_DONE_BIT] <= tx_idle;
        rdata_ff[uart_stat_pkg::ES_TX_EMPTY_BIT] <= tx_empty;
        rdata_ff[uart_stat_pkg::ES_CTS_BIT] <= clear_to_send_pin_i;
        rdata_ff[uart_stat_pkg::ES_RTS_BIT] <= rts_ff;
        rdata_ff[uart_stat_pkg::ES_TX_FULL_BIT] <= !tx_space;
        rdata_ff[uart_stat_pkg::ES_OVERRUN_BIT] <= overrun_ff;
        rdata_ff[uart_stat_pkg::ES_TX_IDLE_BIT] <= core_i.tx_shift_idle;
        rdata_ff[uart_stat_pkg::ES_RX_IDLE_BIT] <= core_i.rx_shift_idle;
        rdata_ff[uart_stat_pkg::ES_TX_SPACE_BIT] <= tx_space;
        rdata_ff[uart_stat_pkg::ES_RX_AVAIL_BIT] <= (core_i.rx_level != 4'h0);
      end
    end
  end

  assign rdata_o = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  // Overrun flag and receive storage.

  overrun_set_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    rx_char_done_i && rx_full
    |=> overrun_ff)
    else $error("overrun not set");

  overrun_clear_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    rd_line_status && !(rx_char_done_i && rx_full)
    |=> !overrun_ff)
    else $error("overrun not cleared by read");

  overrun_hold_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    overrun_ff && !rd_line_status
    |=> overrun_ff)
    else $error("overrun lost without a clearing read");

  stat_overrun_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    rd_i && addr_i == uart_stat_pkg::EXTRA_STATUS_OFFS
    |=> rdata_o[uart_stat_pkg::ES_OVERRUN_BIT] == $past(overrun_ff))
    else $error("extra status overrun wrong");

  drop_full_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    rx_full
    |-> !rx_store_o)
    else $error("stored into full fifo");

  store_room_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    rx_char_done_i && core_i.rx_level < uart_stat_pkg::FIFO_DEPTH
    |-> rx_store_o)
    else $error("character with room not stored");

  ////////////////////////////////////////////////////////////////////////////////
  // Start gating. These only look at symbol starts; a symbol in flight is never cut.

  cts_hold_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ctrl_ff.tx_flow_en && !cts_asserted
    |-> !tx_start_ok_o)
    else $error("start while cts deasserted");

  tx_free_run_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !ctrl_ff.tx_flow_en && ctrl_ff.tx_en && tx_start_req_i && core_i.tx_level != 4'h0
    |-> tx_start_ok_o)
    else $error("transmit held without flow control");

  tx_empty_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    core_i.tx_level == 4'h0
    |-> !tx_start_ok_o)
    else $error("start with empty transmit fifo");

  tx_disable_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !ctrl_ff.tx_en
    |-> !tx_start_ok_o)
    else $error("start while tx disabled");

  rx_disable_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !ctrl_ff.rx_en
    |-> !rx_start_ok_o)
    else $error("rx start while disabled");

  rx_start_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ctrl_ff.rx_en && rx_start_req_i
    |-> rx_start_ok_o)
    else $error("enabled receiver refused a start");

  ////////////////////////////////////////////////////////////////////////////////
  // Request-to-send. The pin is registered, so each check on the pin looks one cycle later.

  manual_rts_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !ctrl_ff.rx_flow_en ##1 !ctrl_ff.rx_flow_en
    |-> request_to_send_pin_o == !$past(modem_rts_ff))
    else $error("manual rts wrong");

  auto_rts_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ctrl_ff.rx_flow_en && !ctrl_ff.rts_low_active && rx_free <= rts_threshold
    |=> !request_to_send_pin_o)
    else $error("rts not deasserted");

  rts_low_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ctrl_ff.rx_flow_en && ctrl_ff.rts_low_active && rx_free <= rts_threshold
    |=> request_to_send_pin_o)
    else $error("inverted rts not deasserted");

  rts_reassert_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ctrl_ff.rx_flow_en && !ctrl_ff.rts_low_active && rx_free > rts_threshold
    |=> request_to_send_pin_o)
    else $error("rts not reasserted");

  threshold_code_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ctrl_ff.rts_level == 2'h3
    |-> rts_threshold == 4'h4)
    else $error("threshold code three wrong");

  ////////////////////////////////////////////////////////////////////////////////
  // Register port.

  rdata_hold_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !rd_i
    |=> $stable(rdata_o))
    else $error("read data moved without a read");

  scratch_write_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    wr_i && addr_i == uart_stat_pkg::SCRATCH_BYTE_OFFS
    |=> scratch_ff == $past(wdata_i[7:0]))
    else $error("scratch write lost");

  scratch_keep_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !(wr_i && addr_i == uart_stat_pkg::SCRATCH_BYTE_OFFS)
    |=> $stable(scratch_ff))
    else $error("scratch changed without a write");

  ctrl_write_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    wr_i && addr_i == uart_stat_pkg::EXTRA_CONTROL_OFFS
    |=> ctrl_ff == $past(wdata_i[7:0]))
    else $error("control write lost");

  modem_write_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    wr_i && addr_i == uart_stat_pkg::MODEM_CONTROL_OFFS
    |=> modem_rts_ff == $past(wdata_i[uart_stat_pkg::MC_RTS_BIT]))
    else $error("manual rts write lost");

  lsr_read_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    rd_line_status
    |=> rdata_o[uart_stat_pkg::LS_TX_IDLE_BIT] == $past(tx_idle))
    else $error("tx idle readback wrong");

  tx_space_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    rd_line_status
    |=> rdata_o[uart_stat_pkg::LS_TX_SPACE_BIT] == ($past(core_i.tx_level) != 4'h8))
    else $error("tx space readback wrong");

  data_ready_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    rd_line_status
    |=> rdata_o[uart_stat_pkg::LS_DATA_READY_BIT] == ($past(core_i.rx_level) != 4'h0))
    else $error("data ready readback wrong");

  lsr_overrun_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    rd_line_status
    |=> rdata_o[uart_stat_pkg::LS_OVERRUN_BIT] == $past(overrun_ff))
    else $error("overrun readback wrong");

  msr_read_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
    rd_i && addr_i == uart_stat_pkg::MODEM_STATUS_OFFS
    |=> rdata_o[uart_stat_pkg::MS_CTS_INV_BIT] != $past(clear_to_send_pin_i))
    else $error("cts status wrong");

endmodule : uart_status_and_flow_control

// ==== sim/remote_flow_partner.sv ====
`timescale 1ns/10ps

module remote_flow_partner
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic busy_i,
  input wire logic low_active_i,
  output logic cts_pin_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // The remote device drives our clear-to-send as its own ready line.
  // It only moves just after a clock edge, so the block never sees a mid-cycle change.
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      cts_pin_o <= 1'h1;
    else
      cts_pin_o <= low_active_i ? busy_i : !busy_i;
  end

endmodule : remote_flow_partner

// ==== sim/uart_status_and_flow_control_bench.sv ====
`timescale 1ns/10ps

module uart_status_and_flow_control_bench;

  logic clock_i = 1'h0;
  logic nrst_i = 1'h0;
  logic [31:0] addr_i = 32'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'h0;
  logic rd_i = 1'h0;
  logic [31:0] rdata_o;
  uart_stat_pkg::core_status_type core_i = 10'h003;
  logic rx_char_done_i = 1'h0;
  logic tx_start_req_i = 1'h1;
  logic rx_start_req_i = 1'h1;
  logic clear_to_send_pin_i, request_to_send_pin_o, tx_start_ok_o, rx_start_ok_o, rx_store_o;
  logic busy = 1'h0;
  logic low_act = 1'h0;
  logic pin, exp;
  logic [3:0] lvl;
  int thr;
  int fails = 0;
  int samples_checked = 0;

  uart_status_and_flow_control i_dut (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .core_i(core_i),
    .rx_char_done_i(rx_char_done_i), .tx_start_req_i(tx_start_req_i),
    .rx_start_req_i(rx_start_req_i), .clear_to_send_pin_i(clear_to_send_pin_i),
    .request_to_send_pin_o(request_to_send_pin_o), .tx_start_ok_o(tx_start_ok_o),
    .rx_start_ok_o(rx_start_ok_o), .rx_store_o(rx_store_o));

  remote_flow_partner i_partner (.clock_i(clock_i), .nrst_i(nrst_i), .busy_i(busy),
    .low_active_i(low_act), .cts_pin_o(clear_to_send_pin_i));

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #2 clock_i = ~clock_i;
  end

  task automatic conclude;
    $display("compares %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    samples_checked++;
    if (got !== want)
    begin
      fails++;
      $display("ERROR at %0t got %h expected %h", $time, got, want);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'h1;
    @(posedge clock_i);
    wr_i <= 1'h0;
  endtask : wr

  // Reserved bits read back as zero; every read is masked to the bits under test.
  task automatic rdc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'h1;
    @(posedge clock_i);
    rd_i <= 1'h0;
    #1 chk(rdata_o & m, e);
  endtask : rdc

  // Two edges cover the registered pin plus the input change landing off the edge.
  task automatic pause;
    repeat (2) @(posedge clock_i);
    #1;
  endtask : pause

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #100000;
    fails++;
    conclude();
  end

  initial
  begin
    repeat (3) @(posedge clock_i);
    nrst_i <= 1'h1;
    #1 chk({31'h0, request_to_send_pin_o}, 32'h1);
    rdc(uart_stat_pkg::LINE_STATUS_OFFS, 32'h63, 32'h60);
    rdc(uart_stat_pkg::EXTRA_STATUS_OFFS, 32'h0F0F_03FF, 32'h0000_03CE);
    rdc(uart_stat_pkg::MODEM_STATUS_OFFS, 32'h20, 32'h0);
    rdc(uart_stat_pkg::SCRATCH_BYTE_OFFS, 32'hFF, 32'h0);
    rdc(uart_stat_pkg::EXTRA_CONTROL_OFFS, 32'hFF, 32'h3);
    rdc(32'h7E21_5070, 32'hFFFF_FFFF, 32'h0);
    wr(uart_stat_pkg::SCRATCH_BYTE_OFFS, 32'hA5);
    rdc(uart_stat_pkg::SCRATCH_BYTE_OFFS, 32'hFF, 32'hA5);
    for (int i = 0; i < 9; i++)
    begin
      lvl = 4'((i / 2) * 2);
      core_i <= {lvl, 4'(8 - i), i[0], 1'h1};
      rdc(uart_stat_pkg::LINE_STATUS_OFFS, 32'h61,
          {25'h0, lvl == 4'h0 && i[0], lvl != 4'h8, 4'h0, i != 8});
    end
    core_i.rx_level <= 4'h8;
    @(posedge clock_i);
    rx_char_done_i <= 1'h1;
    #1 chk({31'h0, rx_store_o}, 32'h0);
    @(posedge clock_i);
    rx_char_done_i <= 1'h0;
    rdc(uart_stat_pkg::EXTRA_STATUS_OFFS, 32'h10, 32'h10);
    rdc(uart_stat_pkg::EXTRA_STATUS_OFFS, 32'h10, 32'h10);
    rdc(uart_stat_pkg::LINE_STATUS_OFFS, 32'h2, 32'h2);
    rdc(uart_stat_pkg::LINE_STATUS_OFFS, 32'h2, 32'h0);
    core_i.rx_level <= 4'h7;
    @(posedge clock_i);
    rx_char_done_i <= 1'h1;
    #1 chk({31'h0, rx_store_o}, 32'h1);
    @(posedge clock_i);
    rx_char_done_i <= 1'h0;
    rdc(uart_stat_pkg::LINE_STATUS_OFFS, 32'h2, 32'h0);
    busy <= 1'h1;
    pause();
    rdc(uart_stat_pkg::MODEM_STATUS_OFFS, 32'h20, 32'h20);
    core_i.tx_level <= 4'h2;
    for (int i = 0; i < 32; i++)
    begin
      busy <= i[0];
      low_act <= i[1];
      wr(uart_stat_pkg::EXTRA_CONTROL_OFFS, {24'h0, i[2], 3'h0, i[3], 1'h1, i[4], i[1]});
      pause();
      pin = i[1] ? i[0] : !i[0];
      exp = i[4] && (!i[3] || (i[2] ? !pin : pin));
      chk({31'h0, tx_start_ok_o}, {31'h0, exp});
      chk({31'h0, rx_start_ok_o}, {31'h0, i[1]});
    end
    for (int c = 0; c < 8; c++)
    begin
      wr(uart_stat_pkg::EXTRA_CONTROL_OFFS, {24'h0, 1'h0, c[2], c[1:0], 4'h7});
      thr = (c[1:0] == 2'h0) ? 3 : (c[1:0] == 2'h1) ? 2 : (c[1:0] == 2'h2) ? 1 : 4;
      for (int l = 0; l < 9; l++)
      begin
        core_i.rx_level <= 4'(l);
        pause();
        exp = ((8 - l) > thr) ^ c[2];
        chk({31'h0, request_to_send_pin_o}, {31'h0, exp});
      end
      core_i.rx_level <= 4'h0;
      pause();
      chk({31'h0, request_to_send_pin_o}, {31'h0, !c[2]});
    end
    wr(uart_stat_pkg::EXTRA_CONTROL_OFFS, 32'h3);
    wr(uart_stat_pkg::MODEM_CONTROL_OFFS, 32'h2);
    pause();
    chk({31'h0, request_to_send_pin_o}, 32'h0);
    wr(uart_stat_pkg::MODEM_CONTROL_OFFS, 32'h0);
    pause();
    chk({31'h0, request_to_send_pin_o}, 32'h1);
    chk({31'h0, tx_start_ok_o}, 32'h1);
    chk({31'h0, rx_start_ok_o}, 32'h1);
    tx_start_req_i <= 1'h0;
    rx_start_req_i <= 1'h0;
    pause();
    chk({31'h0, tx_start_ok_o}, 32'h0);
    chk({31'h0, rx_start_ok_o}, 32'h0);
    conclude();
  end

endmodule : uart_status_and_flow_control_bench
